/* sfwg_host_model.sv */
`timescale 1ns/10ps
module sfwg_host_model (
   input  wire logic       clk_i,   // bench core clock, paces the link
   input  wire logic       quad_i,  // four lines per clock
   input  wire logic       mode3_i, // clock idles high between frames
   input  wire logic       io1_i,   // line 1 as the device drives it
   output logic            cs_n_o,  // chip select, active low
   output logic            sclk_o,  // serial clock, mode 0 or 3
   output logic            io0_o,   // line 0 to the device
   output logic [2:0]      io_hi_o  // lines 3..1 to the device
);
   // ****************************************************************
   // host controller, msb first, one or four lines
   // ****************************************************************
   logic [7:0] rx_byte = 8'h00; // line 1 seen at the last eight rising edges

   initial begin
      cs_n_o  = 1'b1;
      sclk_o  = 1'b0;
      io0_o   = 1'b0;
      io_hi_o = 3'b111;
   end

   task automatic hold(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   // sends the top nbits of frame; a short count gives a broken byte on purpose
   task automatic send(input logic [39:0] frame, input int nbits);
      int step;
      step = quad_i ? 4 : 1;
      // a mode change moves the idle clock level while still deselected
      if (sclk_o !== mode3_i) begin
         sclk_o = mode3_i;
         hold(4);
      end
      cs_n_o = 1'b0;
      for (int i = 0; i < nbits; i += step) begin
         // mode 3 drops the clock here; mode 0 already idles low
         sclk_o = 1'b0;
         {io_hi_o, io0_o} = quad_i ? 4'(frame >> (36 - i)) : {3'b111, frame[39 - i]};
         hold(4);
         sclk_o = 1'b1;
         rx_byte = {rx_byte[6:0], io1_i};
         hold(4);
      end
      sclk_o = mode3_i;
      hold(4);
      cs_n_o = 1'b1;
      // released lines: line 0 and 1 show the inverse, lines 2 and 3 their pull-ups
      io0_o   = ~io0_o;
      io_hi_o = {2'b11, ~io_hi_o[0]};
      hold(8);
   endtask
endmodule // sfwg_host_model

/* sfwg_pkg.sv */
// ****************************************************************
// serial flash write guard: shared constants and types
// ****************************************************************
package sfwg_pkg;
   // command codes
   localparam logic [7:0] CMD_SET_WRITE_LATCH = 8'h06;
   localparam logic [7:0] CMD_CLR_WRITE_LATCH = 8'h04;
   localparam logic [7:0] CMD_READ_STATUS     = 8'h05;
   localparam logic [7:0] CMD_WRITE_STATUS    = 8'h01;
   localparam logic [7:0] CMD_PROG_PAGE       = 8'h02;
   localparam logic [7:0] CMD_PROG_QUAD       = 8'h38;
   localparam logic [7:0] CMD_ERASE_4K        = 8'h20;
   localparam logic [7:0] CMD_ERASE_32K       = 8'h52;
   localparam logic [7:0] CMD_ERASE_64K       = 8'hD8;
   localparam logic [7:0] CMD_ERASE_CHIP      = 8'h60;
   localparam logic [7:0] CMD_ERASE_CHIP_ALT  = 8'hC7;
   localparam logic [7:0] CMD_DEEP_SLEEP      = 8'hB9;
   // whole bytes expected per command, counted up to LEN_PROG_MIN
   localparam logic [2:0] LEN_SHORT    = 3'h1;
   localparam logic [2:0] LEN_STATUS   = 3'h2;
   localparam logic [2:0] LEN_ERASE    = 3'h4;
   localparam logic [2:0] LEN_PROG_MIN = 3'h5;
   // status byte layout
   localparam int         ST_BUSY_POS  = 0;
   localparam int         ST_LATCH_POS = 1;
   localparam int         ST_LEVEL_LO  = 2;
   localparam int         ST_SRWD_POS  = 7;
   localparam logic [3:0] LEVEL_RST    = 4'h0;
   localparam logic [3:0] LEVEL_ALL    = 4'h6;
   localparam logic [5:0] BLOCK_COUNT  = 6'h20;
   localparam int         BLK_LO       = 16;
   localparam logic [8:0] PAGE_BYTES   = 9'h100;
   // synchronised pin vector positions
   localparam int         PIN_CS   = 0;
   localparam int         PIN_SCLK = 1;
   localparam int         PIN_IO0  = 2;
   localparam int         PIN_W    = 6;

   typedef enum logic [2:0] {
      OP_NONE   = 3'b000,
      OP_PROG   = 3'b001,
      OP_ER4K   = 3'b010,
      OP_ER32K  = 3'b011,
      OP_ER64K  = 3'b100,
      OP_ERCHIP = 3'b101
   } sfwg_op_t;

   typedef enum logic [1:0] {
      FR_STANDBY = 2'b00,
      FR_SHIFT   = 2'b01,
      FR_IGNORE  = 2'b10
   } sfwg_frame_t;

   typedef struct packed {
      sfwg_op_t    kind;
      logic [23:0] addr;
      logic [8:0]  len;
   } sfwg_op_req_t;
endpackage

/* sfwg_top.sv */
`timescale 1ns/10ps
module sfwg_top
   import sfwg_pkg::*;
(
   input  wire logic                  ref_clk_i,          // 40 MHz core clock
   input  wire logic                  srst_i,             // sync reset, high
   input  wire logic                  cs_n_i,             // chip select pin
   input  wire logic                  sclk_i,             // host serial clock pin
   input  wire logic                  data_in_io0_i,      // line 0 in
   output logic                       data_in_io0_o,      // line 0 out
   output logic                       data_in_io0_oe_n_o, // line 0 drive, low
   input  wire logic                  data_out_io1_i,     // line 1 in
   output logic                       data_out_io1_o,     // line 1 out
   output logic                       data_out_io1_oe_n_o,// line 1 drive, low
   input  wire logic                  protect_pin_io2_i,  // protect pin / line 2 in
   output logic                       protect_pin_io2_o,  // line 2 out
   output logic                       protect_pin_io2_oe_n_o, // line 2 drive, low
   input  wire logic                  reset_pin_io3_i,    // reset pin / line 3 in
   output logic                       reset_pin_io3_o,    // line 3 out
   output logic                       reset_pin_io3_oe_n_o,   // line 3 drive, low
   input  wire logic                  quad_command_mode_i,// four-line mode
   input  wire logic                  top_bottom_i,       // protect from block 0
   input  wire logic                  op_done_i,          // array engine finished
   input  wire logic [7:0]            page_rd_idx_i,      // page buffer index
   output logic [7:0]                 page_rd_data_o,     // page buffer byte
   output logic                       op_start_o,         // start pulse
   output sfwg_pkg::sfwg_op_req_t     op_req_o,           // operation request
   output logic [7:0]                 status_o,           // status byte
   output logic                       standby_o,          // idle indication
   output logic                       deep_sleep_o        // deep sleep state
);
   import sfwg_pkg::*;

   // ****************************************************************
   // pin synchronisers and edge detection
   // ****************************************************************
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] sync1_reg;
   logic [PIN_W-1:0] sync2_reg;
   logic             cs_d_reg;
   logic             sclk_d_reg;

   assign pin_raw = {reset_pin_io3_i, protect_pin_io2_i, data_out_io1_i, data_in_io0_i, sclk_i, cs_n_i};

   always_ff @(posedge ref_clk_i) begin
      sync1_reg  <= pin_raw;
      sync2_reg  <= sync1_reg;
      cs_d_reg   <= srst_i ? 1'b1 : sync2_reg[PIN_CS];
      sclk_d_reg <= sync2_reg[PIN_SCLK];
   end

   wire       cs_s      = sync2_reg[PIN_CS];
   wire [3:0] io_s      = sync2_reg[PIN_IO0+3:PIN_IO0];
   wire       cs_fall   = ~cs_s & cs_d_reg;
   wire       cs_rise   = cs_s & ~cs_d_reg;
   // sampling on rising edges only serves both idle levels of the clock
   wire       sclk_rise = sync2_reg[PIN_SCLK] & ~sclk_d_reg;
   wire       sclk_fall = ~sync2_reg[PIN_SCLK] & sclk_d_reg;

   // ****************************************************************
   // frame shifter
   // ****************************************************************
   sfwg_frame_t frame_reg;
   logic [2:0]  bit_reg;
   logic [2:0]  byte_reg;
   logic [8:0]  data_cnt_reg;
   logic [7:0]  sh_reg;
   logic [7:0]  cmd_reg;
   logic [7:0]  wsr_data_reg;
   logic [23:0] addr_reg;
   logic [7:0]  page_mem [0:255];
   logic        sleep_reg;
   logic        wel_reg;
   logic        wip_reg;
   logic        srwd_reg;
   logic [3:0]  level_reg;
   logic        rdsr_reg;
   logic [2:0]  out_idx_reg;
   logic        io1_out_reg;
   logic        op_start_reg;
   sfwg_op_req_t op_req_reg;

   wire        shift_edge = sclk_rise & ~cs_s & (frame_reg == FR_SHIFT);
   wire [2:0]  bit_next   = quad_command_mode_i ? 3'(bit_reg + 3'h4) : 3'(bit_reg + 3'h1);
   wire [7:0]  sh_next    = quad_command_mode_i ? {sh_reg[3:0], io_s} : {sh_reg[6:0], io_s[0]};
   wire        byte_done  = shift_edge & (bit_next == 3'h0);
   wire        cmd_byte   = byte_done & (byte_reg == 3'h0);

   // ****************************************************************
   // command decode and guard
   // ****************************************************************
   wire is_set_write_latch_cmd  = cmd_reg == CMD_SET_WRITE_LATCH;
   wire is_wrdi  = cmd_reg == CMD_CLR_WRITE_LATCH;
   wire is_wrsr  = cmd_reg == CMD_WRITE_STATUS;
   wire is_prog  = (cmd_reg == CMD_PROG_PAGE) | (cmd_reg == CMD_PROG_QUAD);
   wire is_er4k  = cmd_reg == CMD_ERASE_4K;
   wire is_er32k = cmd_reg == CMD_ERASE_32K;
   wire is_er64k = cmd_reg == CMD_ERASE_64K;
   wire is_erase = is_er4k | is_er32k | is_er64k;
   wire is_ce    = (cmd_reg == CMD_ERASE_CHIP) | (cmd_reg == CMD_ERASE_CHIP_ALT);
   wire is_dp    = cmd_reg == CMD_DEEP_SLEEP;
   wire is_short = is_set_write_latch_cmd | is_wrdi | is_ce | is_dp;
   wire is_start = is_prog | is_erase | is_ce;

   wire len_ok = (bit_reg == 3'h0)
               & ((is_short & byte_reg == LEN_SHORT) | (is_wrsr & byte_reg == LEN_STATUS)
               | (is_erase & byte_reg == LEN_ERASE) | (is_prog & byte_reg == LEN_PROG_MIN));
   wire need_wel = is_wrsr | is_start;

   wire [5:0] blk       = {1'b0, addr_reg[BLK_LO+4:BLK_LO]};
   wire [2:0] lvl_m1    = 3'(level_reg[2:0] - 3'h1);
   wire [5:0] n_blk     = 6'h01 << lvl_m1;
   wire [5:0] top_first = 6'(BLOCK_COUNT - n_blk);
   wire       lvl_all   = level_reg >= LEVEL_ALL;
   wire       blk_prot  = lvl_all | ((level_reg != 4'h0)
                        & (top_bottom_i ? (blk < n_blk)
                                        : (blk >= top_first)));
   wire       ce_ok     = level_reg == 4'h0;
   wire       prot_hit  = ((is_prog | is_erase) & blk_prot) | (is_ce & ~ce_ok);
   // pin protection only while the pin is a pin, not a data line
   wire       pin_lock  = ~io_s[2] & ~quad_command_mode_i;
   wire       frame_end = cs_rise & (frame_reg == FR_SHIFT);
   // any failed check leaves array and status alone
   wire       accept    = frame_end & len_ok & ~prot_hit & ~wip_reg
                        & (~need_wel | wel_reg);

   sfwg_op_t op_kind;
   assign op_kind = is_prog  ? OP_PROG  : is_er4k  ? OP_ER4K :
                    is_er32k ? OP_ER32K : is_er64k ? OP_ER64K :
                    is_ce    ? OP_ERCHIP : OP_NONE;

   // ****************************************************************
   // frame state
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         frame_reg <= FR_STANDBY;
         sleep_reg <= 1'b0;
      end else begin
         unique case (frame_reg)
            FR_STANDBY: begin
               if (cs_fall) begin
                  // apart from reset, a select toggle is the only thing that ends deep sleep
                  frame_reg <= sleep_reg ? FR_IGNORE : FR_SHIFT;
                  sleep_reg <= 1'b0;
               end
            end
            FR_SHIFT: begin
               if (cs_rise) begin
                  frame_reg <= FR_STANDBY;
               end
               if (accept & is_dp) begin
                  sleep_reg <= 1'b1;
               end
            end
            FR_IGNORE: begin
               if (cs_rise) begin
                  frame_reg <= FR_STANDBY;
               end
            end
            default: frame_reg <= FR_STANDBY;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (srst_i | (frame_reg != FR_SHIFT)) begin
         bit_reg      <= 3'h0;
         byte_reg     <= 3'h0;
         data_cnt_reg <= 9'h000;
      end else if (shift_edge) begin
         bit_reg <= bit_next;
         if (byte_done & (byte_reg != LEN_PROG_MIN)) begin
            byte_reg <= 3'(byte_reg + 3'h1);
         end
         if (byte_done & (byte_reg >= LEN_ERASE) & (data_cnt_reg != PAGE_BYTES)) begin
            data_cnt_reg <= 9'(data_cnt_reg + 9'h001);
         end
      end
   end

   // data beyond one page all lands on buffer entry 0; the count saturates at PAGE_BYTES
   always_ff @(posedge ref_clk_i) begin
      if (shift_edge) begin
         sh_reg <= sh_next;
      end
      if (cmd_byte) begin
         cmd_reg <= sh_next;
      end
      if (byte_done & (byte_reg == 3'h1)) begin
         wsr_data_reg <= sh_next;
      end
      if (byte_done & (byte_reg != 3'h0) & (byte_reg < LEN_ERASE)) begin
         addr_reg <= {addr_reg[15:0], sh_next};
      end
      if (byte_done & (byte_reg >= LEN_ERASE)) begin
         page_mem[data_cnt_reg[7:0]] <= sh_next;
      end
   end

   // ****************************************************************
   // status bits and operation launch
   // ****************************************************************
   always_ff @(posedge ref_clk_i) begin
      if (srst_i) begin
         wel_reg      <= 1'b0;
         wip_reg      <= 1'b0;
         srwd_reg     <= 1'b0;
         level_reg    <= LEVEL_RST;
         op_start_reg <= 1'b0;
         op_req_reg   <= '0;
      end else begin
         op_start_reg <= accept & is_start;
         if (accept & is_start) begin
            op_req_reg <= '{kind: op_kind, addr: addr_reg, len: data_cnt_reg};
            wip_reg    <= 1'b1;
         end else if (op_done_i) begin
            wip_reg    <= 1'b0;
         end
         if (op_done_i & wip_reg) begin
            wel_reg <= 1'b0;
         end else if (accept & (is_wrdi | is_wrsr)) begin
            wel_reg <= 1'b0;
         end else if (accept & is_set_write_latch_cmd) begin
            wel_reg <= 1'b1;
         end
         if (accept & is_wrsr & ~pin_lock) begin
            level_reg <= wsr_data_reg[ST_LEVEL_LO+3:ST_LEVEL_LO];
            srwd_reg  <= wsr_data_reg[ST_SRWD_POS];
         end
      end
   end

   wire [7:0] status_w = {srwd_reg, 1'b0, level_reg, wel_reg, wip_reg};

   // ****************************************************************
   // status read output on line 1, single-line mode only
   // ****************************************************************
   // output moves about three core cycles after the falling clock edge
   always_ff @(posedge ref_clk_i) begin
      if (srst_i | cs_rise) begin
         rdsr_reg    <= 1'b0;
         out_idx_reg <= 3'h0;
         io1_out_reg <= 1'b0;
      end else begin
         if (cmd_byte & (sh_next == CMD_READ_STATUS) & ~quad_command_mode_i) begin
            rdsr_reg <= 1'b1;
         end
         if (rdsr_reg & sclk_fall) begin
            io1_out_reg <= status_w[3'h7 - out_idx_reg];
            out_idx_reg <= 3'(out_idx_reg + 3'h1);
         end
      end
   end

   assign data_in_io0_o          = 1'b0;
   assign data_in_io0_oe_n_o     = 1'b1;
   assign data_out_io1_o         = io1_out_reg;
   assign data_out_io1_oe_n_o    = ~rdsr_reg;
   assign protect_pin_io2_o      = 1'b0;
   assign protect_pin_io2_oe_n_o = 1'b1;
   assign reset_pin_io3_o        = 1'b0;
   assign reset_pin_io3_oe_n_o   = 1'b1;
   assign page_rd_data_o         = page_mem[page_rd_idx_i];
   assign op_start_o             = op_start_reg;
   assign op_req_o               = op_req_reg;
   assign status_o               = status_w;
   assign standby_o              = (frame_reg == FR_STANDBY) & ~wip_reg;
   assign deep_sleep_o           = sleep_reg;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (srst_i);

   chk_reset_standby: assert property ($fell(srst_i) |-> frame_reg == FR_STANDBY && !wip_reg && !wel_reg)
      else $error("not in standby after reset");
   chk_start_after_end: assert property (op_start_o |-> $past(cs_rise) && $past(frame_reg) == FR_SHIFT)
      else $error("operation started without frame end");
   chk_len_whole: assert property (op_start_o |-> $past(bit_reg) == 3'h0)
      else $error("operation started on partial byte");
   chk_latch_needed: assert property (op_start_o |-> $past(wel_reg))
      else $error("operation started without write latch");
   chk_sleep_quiet: assert property (sleep_reg && $past(sleep_reg) |-> !op_start_o && $stable(wel_reg))
      else $error("activity during deep sleep");
   chk_prot_refused: assert property (op_start_o && op_req_o.kind != OP_ERCHIP |-> !$past(blk_prot))
      else $error("protected block altered");
   chk_prot_top: assert property (!top_bottom_i && level_reg == 4'h3 |-> blk_prot == (blk >= 6'h1C))
      else $error("top level 3 region wrong");
   chk_prot_all: assert property (level_reg >= 4'h6 |-> blk_prot)
      else $error("high level does not guard all");
   chk_prot_bottom: assert property (top_bottom_i && level_reg == 4'h5 |-> blk_prot == (blk < 6'h10))
      else $error("bottom level 5 region wrong");
   chk_pin_hold: assert property (accept && is_wrsr && pin_lock |=> $stable(level_reg) && $stable(srwd_reg))
      else $error("level bits changed under pin lock");
   chk_quad_unlock: assert property (quad_command_mode_i |-> !pin_lock)
      else $error("pin lock active in quad mode");
   chk_busy_start: assert property ($rose(wip_reg) |-> op_start_o ##1 wip_reg)
      else $error("busy without start");
   chk_chip_erase: assert property (op_start_o && op_req_o.kind == OP_ERCHIP |-> $past(level_reg) == 4'h0)
      else $error("chip erase with level set");
   chk_latch_done: assert property (op_done_i && wip_reg |=> !wel_reg && !wip_reg)
      else $error("latch not cleared at completion");
   chk_standby_idle: assert property (cs_s && cs_d_reg && $past(cs_d_reg) && !wip_reg |-> standby_o)
      else $error("not standby while idle");

   cov_program: cover property (op_start_o && op_req_o.kind == OP_PROG);
   cov_refused: cover property (frame_end && len_ok && wel_reg && prot_hit);
   cov_status_read: cover property (rdsr_reg && sclk_fall);
   cov_sleep_wake: cover property (sleep_reg ##1 !sleep_reg);
endmodule // sfwg_top

/* test_serial_flash_write_guard.sv */
`timescale 1ns/10ps
module test_serial_flash_write_guard;
   import sfwg_pkg::*;
   logic         clk = 1'b0;
   logic         srst = 1'b1;
   logic         cs_n, sclk, io0;
   logic         wp_n = 1'b1;
   logic         tb_sel = 1'b0;
   logic         done = 1'b0;
   logic         start, standby, sleep;
   logic         quad = 1'b0;
   logic         mode3 = 1'b0;
   logic         io1_dev, oe1_n;
   logic [2:0]   io_hi, pin_out, pin_oe_n;
   logic [7:0]   page_byte;
   wire          io1_back = oe1_n ? 1'b0 : io1_dev;
   logic [7:0]   status;
   sfwg_op_req_t req;
   int           fails = 0;
   int           total_checks = 0;
   int           starts = 0;

   always #12.5 clk = ~clk;
   always @(posedge clk) if (start === 1'b1) starts++;

   sfwg_host_model u_host (.clk_i(clk), .quad_i(quad), .mode3_i(mode3), .io1_i(io1_back),
      .cs_n_o(cs_n), .sclk_o(sclk), .io0_o(io0), .io_hi_o(io_hi));
   // the protect pin is pulled low by the board when wp_n is low
   sfwg_top u_dut (
      .ref_clk_i(clk), .srst_i(srst), .cs_n_i(cs_n), .sclk_i(sclk),
      .data_in_io0_i(io0), .data_in_io0_o(pin_out[0]), .data_in_io0_oe_n_o(pin_oe_n[0]),
      .data_out_io1_i(io_hi[0]), .data_out_io1_o(io1_dev), .data_out_io1_oe_n_o(oe1_n),
      .protect_pin_io2_i(io_hi[1] & wp_n), .protect_pin_io2_o(pin_out[1]),
      .protect_pin_io2_oe_n_o(pin_oe_n[1]),
      .reset_pin_io3_i(io_hi[2]), .reset_pin_io3_o(pin_out[2]), .reset_pin_io3_oe_n_o(pin_oe_n[2]),
      .quad_command_mode_i(quad), .top_bottom_i(tb_sel), .op_done_i(done),
      .page_rd_idx_i(8'h00), .page_rd_data_o(page_byte), .op_start_o(start), .op_req_o(req),
      .status_o(status), .standby_o(standby), .deep_sleep_o(sleep));

   // ****************************************************************
   // shared helpers
   // ****************************************************************
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic pulse_done();
      int n;
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      n = 0;
      while (standby !== 1'b1 && n < 60) begin
         @(negedge clk);
         n++;
      end
      if (standby !== 1'b1) begin
         fails++;
         finish_test();
      end
   endtask

   task automatic write_latch_bit();
      u_host.send({CMD_SET_WRITE_LATCH, 32'h0}, 8);
   endtask

   task automatic set_level(input logic [3:0] lvl);
      write_latch_bit();
      u_host.send({CMD_WRITE_STATUS, 2'b00, lvl, 2'b00, 24'h0}, 16);
      if (status[ST_BUSY_POS] === 1'b1) pulse_done();
      u_host.send({CMD_CLR_WRITE_LATCH, 32'h0}, 8);
   endtask

   function automatic sfwg_op_t kind_of(input logic [7:0] c);
      case (c)
         CMD_ERASE_4K:  return OP_ER4K;
         CMD_ERASE_32K: return OP_ER32K;
         CMD_ERASE_64K: return OP_ER64K;
         default:       return OP_ERCHIP;
      endcase
   endfunction

   task automatic try_erase(input logic [7:0] c, input int blk, input bit ok);
      int n0;
      n0 = starts;
      write_latch_bit();
      u_host.send({c, 3'b000, 5'(blk), 16'h0000, 8'h00}, (c == CMD_ERASE_CHIP) ? 8 : 32);
      check("erase start", 40'(starts - n0), 40'(ok));
      if (ok) begin
         check("erase kind", 40'(req.kind), 40'(kind_of(c)));
         pulse_done();
      end else
         u_host.send({CMD_CLR_WRITE_LATCH, 32'h0}, 8);
   endtask

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic t_prog();
      int n0;
      n0 = starts;
      u_host.send({CMD_PROG_PAGE, 24'h012345, 8'hA5}, 40);
      check("start without latch", 40'(starts - n0), 40'h0);
      write_latch_bit();
      check("latch", 40'(status[ST_LATCH_POS]), 40'h1);
      u_host.send({CMD_PROG_PAGE, 24'h012345, 8'hA5}, 39);
      check("partial byte start", 40'(starts - n0), 40'h0);
      check("status kept", 40'(status), 40'h02);
      u_host.send({CMD_PROG_PAGE, 24'h012345, 8'hA5}, 40);
      check("prog start", 40'(starts - n0), 40'h1);
      check("prog request", 40'(req), 40'({OP_PROG, 24'h012345, 9'h001}));
      check("page byte", 40'(page_byte), 40'hA5);
      check("busy", 40'(status[ST_BUSY_POS]), 40'h1);
      pulse_done();
      check("status after done", 40'(status), 40'h00);
      $display("test program done");
   endtask

   task automatic t_erase();
      logic [7:0] cmds [4];
      int lo;
      cmds = '{CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_64K, CMD_ERASE_CHIP};
      foreach (cmds[i]) try_erase(cmds[i], 0, 1'b1);
      set_level(4'h1);
      try_erase(CMD_ERASE_CHIP, 0, 1'b0);
      for (int l = 1; l < 6; l++) begin
         lo = 1 << (l - 1);
         set_level(4'(l));
         check("level", 40'(status[5:2]), 40'(l));
         tb_sel = 1'b0;
         try_erase(CMD_ERASE_64K, 32 - lo, 1'b0);
         try_erase(CMD_ERASE_4K, 31 - lo, 1'b1);
         tb_sel = 1'b1;
         try_erase(CMD_ERASE_64K, lo - 1, 1'b0);
         try_erase(CMD_ERASE_32K, lo, 1'b1);
      end
      tb_sel = 1'b0;
      set_level(4'h6);
      try_erase(CMD_ERASE_4K, 0, 1'b0);
      set_level(4'hF);
      try_erase(CMD_ERASE_64K, 16, 1'b0);
      set_level(4'h0);
      $display("test erase done");
   endtask

   task automatic t_pin();
      wp_n = 1'b0;
      set_level(4'h3);
      check("locked level", 40'(status[5:2]), 40'h0);
      wp_n = 1'b1;
      set_level(4'h3);
      check("free level", 40'(status[5:2]), 40'h3);
      set_level(4'h0);
      $display("test pin lock done");
   endtask

   task automatic t_read();
      write_latch_bit();
      u_host.send({CMD_READ_STATUS, 32'h0}, 16);
      check("status read mode 0", 40'(u_host.rx_byte), 40'h02);
      u_host.send({CMD_PROG_PAGE, 24'h000100, 8'h3C}, 40);
      mode3 = 1'b1;
      u_host.send({CMD_READ_STATUS, 32'h0}, 16);
      check("busy read mode 3", 40'(u_host.rx_byte), 40'h03);
      pulse_done();
      u_host.send({CMD_READ_STATUS, 32'h0}, 16);
      check("idle read mode 3", 40'(u_host.rx_byte), 40'h00);
      check("line 1 released", 40'(oe1_n), 40'h1);
      mode3 = 1'b0;
      $display("test status read done");
   endtask

   // with the pin held low, only command and data nibbles with line 2 low get through
   task automatic t_quad();
      quad = 1'b1;
      u_host.send({CMD_SET_WRITE_LATCH, 32'h0}, 8);
      check("quad latch", 40'(status[ST_LATCH_POS]), 40'h1);
      wp_n = 1'b0;
      u_host.send({CMD_WRITE_STATUS, 8'h08, 24'h0}, 16);
      check("quad level", 40'(status[5:2]), 40'h2);
      wp_n = 1'b1;
      quad = 1'b0;
      set_level(4'h0);
      $display("test quad lines done");
   endtask

   task automatic t_sleep();
      u_host.send({CMD_DEEP_SLEEP, 32'h0}, 8);
      check("sleep entered", 40'(sleep), 40'h1);
      write_latch_bit();
      check("sleep left", 40'(sleep), 40'h0);
      check("latch ignored", 40'(status[ST_LATCH_POS]), 40'h0);
      $display("test deep sleep done");
   endtask

   initial begin
      repeat (5) @(negedge clk);
      srst = 1'b0;
      repeat (4) @(negedge clk);
      check("reset status", 40'(status), 40'h00);
      check("reset standby", 40'({standby, sleep, start}), 40'h4);
      check("idle pin drive", 40'({pin_oe_n, oe1_n, pin_out}), 40'h78);
      t_prog();
      t_read();
      t_erase();
      t_pin();
      t_quad();
      t_sleep();
      finish_test();
   end
endmodule // test_serial_flash_write_guard
